// ==== hw/ctl_consts.svh ====
`ifndef CTL_CONSTS_SVH
`define CTL_CONSTS_SVH

// register file size and the index of the pin control register
`define NUM_REGS 5'd23
`define IDX_PIN_CTRL 5'h16
`define BIT_PASSTHRU 0
`define BIT_VSYNC_EN 1

// register defaults
`define DEF_00 8'h01
`define DEF_01 8'h00
`define DEF_02 8'h04
`define DEF_03 8'h01
`define DEF_04 8'h24
`define DEF_05 8'h04
`define DEF_06 8'h48
`define DEF_07 8'h84
`define DEF_08 8'h08
`define DEF_09 8'h9a
`define DEF_0A 8'h99
`define DEF_0B 8'h99
`define DEF_0C 8'h3d
`define DEF_0D 8'h20
`define DEF_0E 8'h59
`define DEF_0F 8'h21
`define DEF_10 8'h31
`define DEF_11 8'h01
`define DEF_12 8'ha0
`define DEF_13 8'h90
`define DEF_14 8'h67
`define DEF_15 8'h88
`define DEF_16 8'h00

// fixed bits of the slave address: 1,0,0,hi,0,1,lo
`define ADDR_TOP 3'h4
`define ADDR_MID 2'h1

// falling reference edges from reset release to normal operation
`define RELEASE_EDGES 3'h4
// bits per byte on the serial bus
`define BYTE_BITS 4'h8

`endif

// ==== hw/ctl_pkg.sv ====
package ctl_pkg;

   // serial slave protocol states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_INDEX,
      ST_INDEX_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } slave_state_t;

   // open-drain pin drive: out is the level driven while oe is high
   typedef struct packed {
      logic out;
      logic oe;
   } od_pin_t;

endpackage : ctl_pkg

// ==== hw/reset_release.sv ====
`timescale 1ns/1ps
`include "ctl_consts.svh"

module reset_release (
   // reference clock and chip reset pin
   input wire logic ref_clock_in,
   input wire logic chip_rst_n,
   // high once normal operation may resume
   output logic run_ok
);

   logic [2:0] edge_cnt_reg;
   logic [2:0] edge_cnt_next;
   logic run_reg;
   logic run_next;

   // count falling reference edges after release, saturating at the limit
   always_comb begin
      edge_cnt_next = edge_cnt_reg;
      if (edge_cnt_reg != `RELEASE_EDGES) begin
         edge_cnt_next = edge_cnt_reg + 3'h1;
      end
      run_next = (edge_cnt_next == `RELEASE_EDGES);
   end

   // asynchronous clear: no reference edge needed to enter reset
   always_ff @(negedge ref_clock_in or negedge chip_rst_n) begin
      if (!chip_rst_n) begin
         edge_cnt_reg <= 3'h0;
         run_reg <= 1'b0;
      end else begin
         edge_cnt_reg <= edge_cnt_next;
         run_reg <= run_next;
      end
   end

   assign run_ok = run_reg;

   property p_release_fourth;
      @(negedge ref_clock_in) disable iff (!chip_rst_n)
      $rose(run_reg) |-> edge_cnt_reg == 3'h4 && $past(edge_cnt_reg) == 3'h3;
   endproperty
   a_release_fourth: assert property (p_release_fourth)
      else $error("run released on the wrong reference edge");

   property p_run_holds;
      @(negedge ref_clock_in) disable iff (!chip_rst_n)
      run_reg |=> run_reg;
   endproperty
   a_run_holds: assert property (p_run_holds)
      else $error("run dropped without a chip reset");

endmodule : reset_release

// ==== hw/ctl_port_core.sv ====
`timescale 1ns/1ps
`include "ctl_consts.svh"

// Overview of operation
// - chip reset pin is active low and takes effect with no clock edge.
// - operation resumes on the fourth falling reference edge after release.
// - every control register is loaded with its default during reset; chip reset here clears them to zero, defaults load after release.
// - slave address is 1,0,0,hi select,0,1,lo select plus direction bit.
// - feed-through data repeats serial data; switch off releases it.
// - feed-through clock repeats serial clock, only pulls low, can release.
// - serial data is only pulled low or released, pull-up gives high.
// - general pin zero can send a vertical pulse as open drain.
// - write sends address, start index, then data into successive registers.
// - read sets index, repeated start, then successive values until stop.
module ctl_port_core
   import ctl_pkg::*;
(
   // clocks and resets
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ref_clock_in,
   input wire logic chip_rst_n,
   // address select straps
   input wire logic addr_sel_lo,
   input wire logic addr_sel_hi,
   // serial control bus
   input wire logic scl_in,
   input wire logic sda_in,
   output od_pin_t sda_pin,
   // tuner feed-through and vertical pulse
   input wire logic vsync_src,
   output od_pin_t ft_sda_pin,
   output od_pin_t ft_scl_pin,
   output od_pin_t vertical_pulse_out,
   // status
   output logic running
);

   logic run_ok;
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [1:0] prev_reg;
   logic [4:0] sync1_next;
   logic [4:0] sync2_next;
   logic [1:0] prev_next;
   logic scl_s;
   logic sda_s;
   logic sel_hi_s;
   logic sel_lo_s;
   logic run_s;
   logic core_rst;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic [6:0] my_addr;
   logic passthru_switch_on;
   logic vsync_en;
   logic [7:0] rd_byte;

   slave_state_t state_reg;
   slave_state_t state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] idx_reg;
   logic [7:0] idx_next;
   logic rw_reg;
   logic rw_next;
   logic nack_reg;
   logic nack_next;
   logic sda_oe_reg;
   logic sda_oe_next;
   logic [7:0] regs_reg [0:22];
   logic [7:0] regs_next [0:22];

   logic ft_sda_oe_reg;
   logic ft_sda_oe_next;
   logic ft_scl_oe_reg;
   logic ft_scl_oe_next;
   logic vs_oe_reg;
   logic vs_oe_next;
   logic run_reg;
   logic run_next;

   // register defaults, also used for the reset load
   function automatic logic [7:0] reg_default(input logic [4:0] i);
      case (i)
         5'h00: reg_default = `DEF_00;
         5'h01: reg_default = `DEF_01;
         5'h02: reg_default = `DEF_02;
         5'h03: reg_default = `DEF_03;
         5'h04: reg_default = `DEF_04;
         5'h05: reg_default = `DEF_05;
         5'h06: reg_default = `DEF_06;
         5'h07: reg_default = `DEF_07;
         5'h08: reg_default = `DEF_08;
         5'h09: reg_default = `DEF_09;
         5'h0a: reg_default = `DEF_0A;
         5'h0b: reg_default = `DEF_0B;
         5'h0c: reg_default = `DEF_0C;
         5'h0d: reg_default = `DEF_0D;
         5'h0e: reg_default = `DEF_0E;
         5'h0f: reg_default = `DEF_0F;
         5'h10: reg_default = `DEF_10;
         5'h11: reg_default = `DEF_11;
         5'h12: reg_default = `DEF_12;
         5'h13: reg_default = `DEF_13;
         5'h14: reg_default = `DEF_14;
         5'h15: reg_default = `DEF_15;
         5'h16: reg_default = `DEF_16;
         default: reg_default = 8'h00;
      endcase
   endfunction : reg_default

   // read path: indices past the file read as zero
   function automatic logic [7:0] reg_at(input logic [7:0] i);
      if (i < {3'h0, `NUM_REGS}) begin
         reg_at = regs_reg[i[4:0]];
      end else begin
         reg_at = 8'h00;
      end
   endfunction : reg_at

   // reference-domain release counter
   reset_release u_release (
      .ref_clock_in(ref_clock_in),
      .chip_rst_n(chip_rst_n),
      .run_ok(run_ok)
   );

   // pins and the release flag are foreign to core_clk: two flops each
   always_comb begin
      sync1_next = {run_ok, addr_sel_lo, addr_sel_hi, sda_in, scl_in};
      sync2_next = sync1_reg;
      prev_next = sync2_reg[1:0];
   end

   always_ff @(posedge core_clk or negedge chip_rst_n) begin
      if (!chip_rst_n) begin
         sync1_reg <= 5'h03;
         sync2_reg <= 5'h03;
         prev_reg <= 2'h3;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
      end
   end

   assign scl_s = sync2_reg[0];
   assign sda_s = sync2_reg[1];
   assign sel_hi_s = sync2_reg[2];
   assign sel_lo_s = sync2_reg[3];
   assign run_s = sync2_reg[4];
   assign core_rst = !resetn || !run_s;
   assign scl_rise = scl_s && !prev_reg[0];
   assign scl_fall = !scl_s && prev_reg[0];
   // data edges while the clock is high mark start and stop
   assign start_ev = scl_s && prev_reg[0] && !sda_s && prev_reg[1];
   assign stop_ev = scl_s && prev_reg[0] && sda_s && !prev_reg[1];
   assign my_addr = {`ADDR_TOP, sel_hi_s, `ADDR_MID, sel_lo_s};
   assign passthru_switch_on = regs_reg[`IDX_PIN_CTRL][`BIT_PASSTHRU];
   assign vsync_en = regs_reg[`IDX_PIN_CTRL][`BIT_VSYNC_EN];

   // byte the read path loads next; a bit of a call result is not selectable
   always_comb begin
      rd_byte = reg_at(idx_reg);
   end

   // serial slave: sample on clock rise, change our data on clock fall
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      idx_next = idx_reg;
      rw_next = rw_reg;
      nack_next = nack_reg;
      sda_oe_next = sda_oe_reg;
      regs_next = regs_reg;
      if (core_rst) begin
         state_next = ST_IDLE;
         cnt_next = 4'h0;
         shift_next = 8'h00;
         idx_next = 8'h00;
         rw_next = 1'b0;
         nack_next = 1'b0;
         sda_oe_next = 1'b0;
         for (int i = 0; i < 23; i++) begin
            regs_next[i] = reg_default(5'(i));
         end
      end else if (start_ev) begin
         // a repeated start keeps the index for the read phase
         state_next = ST_ADDR;
         cnt_next = 4'h0;
         sda_oe_next = 1'b0;
      end else if (stop_ev) begin
         state_next = ST_IDLE;
         sda_oe_next = 1'b0;
      end else if (scl_rise) begin
         case (state_reg)
            ST_ADDR, ST_INDEX, ST_WDATA: begin
               shift_next = {shift_reg[6:0], sda_s};
               cnt_next = cnt_reg + 4'h1;
            end
            ST_RDATA: cnt_next = cnt_reg + 4'h1;
            ST_RDATA_ACK: nack_next = sda_s;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (state_reg)
            ST_ADDR: begin
               if (cnt_reg == `BYTE_BITS) begin
                  if (shift_reg[7:1] == my_addr) begin
                     rw_next = shift_reg[0];
                     state_next = ST_ADDR_ACK;
                     sda_oe_next = 1'b1;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               cnt_next = 4'h0;
               if (rw_reg) begin
                  shift_next = rd_byte;
                  sda_oe_next = !rd_byte[7];
                  state_next = ST_RDATA;
               end else begin
                  sda_oe_next = 1'b0;
                  state_next = ST_INDEX;
               end
            end
            ST_INDEX: begin
               if (cnt_reg == `BYTE_BITS) begin
                  idx_next = shift_reg;
                  state_next = ST_INDEX_ACK;
                  sda_oe_next = 1'b1;
               end
            end
            ST_WDATA: begin
               if (cnt_reg == `BYTE_BITS) begin
                  if (idx_reg < {3'h0, `NUM_REGS}) begin
                     regs_next[idx_reg[4:0]] = shift_reg;
                  end
                  idx_next = idx_reg + 8'h01;
                  state_next = ST_WDATA_ACK;
                  sda_oe_next = 1'b1;
               end
            end
            ST_INDEX_ACK, ST_WDATA_ACK: begin
               sda_oe_next = 1'b0;
               cnt_next = 4'h0;
               state_next = ST_WDATA;
            end
            ST_RDATA: begin
               if (cnt_reg == `BYTE_BITS) begin
                  sda_oe_next = 1'b0; // master answers now
                  idx_next = idx_reg + 8'h01;
                  state_next = ST_RDATA_ACK;
               end else begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  sda_oe_next = !shift_reg[6];
               end
            end
            ST_RDATA_ACK: begin
               cnt_next = 4'h0;
               if (nack_reg) begin
                  state_next = ST_IDLE; // master ends the read
               end else begin
                  shift_next = rd_byte;
                  sda_oe_next = !rd_byte[7];
                  state_next = ST_RDATA;
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   // pin drives: open drain only, so oe alone carries the level
   always_comb begin
      ft_sda_oe_next = passthru_switch_on && !sda_s && !core_rst;
      ft_scl_oe_next = passthru_switch_on && !scl_s && !core_rst;
      vs_oe_next = vsync_en && vsync_src && !core_rst;
      run_next = !core_rst;
   end

   // chip reset clears everything at once, without a clock edge
   always_ff @(posedge core_clk or negedge chip_rst_n) begin
      if (!chip_rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         idx_reg <= 8'h00;
         rw_reg <= 1'b0;
         nack_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         for (int i = 0; i < 23; i++) begin
            regs_reg[i] <= 8'h00; // reloaded with defaults after release, until run
         end
         ft_sda_oe_reg <= 1'b0;
         ft_scl_oe_reg <= 1'b0;
         vs_oe_reg <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         idx_reg <= idx_next;
         rw_reg <= rw_next;
         nack_reg <= nack_next;
         sda_oe_reg <= sda_oe_next;
         regs_reg <= regs_next;
         ft_sda_oe_reg <= ft_sda_oe_next;
         ft_scl_oe_reg <= ft_scl_oe_next;
         vs_oe_reg <= vs_oe_next;
         run_reg <= run_next;
      end
   end

   // driven level is always low; a high comes from the pull-up
   assign sda_pin = '{out: 1'b0, oe: sda_oe_reg};
   assign ft_sda_pin = '{out: 1'b0, oe: ft_sda_oe_reg};
   assign ft_scl_pin = '{out: 1'b0, oe: ft_scl_oe_reg};
   assign vertical_pulse_out = '{out: 1'b0, oe: vs_oe_reg};
   assign running = run_reg;

   property p_reset_quiet;
      @(posedge core_clk) disable iff (!resetn)
      !chip_rst_n |-> !sda_oe_reg && !ft_sda_oe_reg && !ft_scl_oe_reg;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("pins driven during chip reset");

   property p_defaults;
      @(posedge core_clk) disable iff (!chip_rst_n)
      // the edge that leaves chip reset still clears, so it starts no attempt
      chip_rst_n && !resetn |=> regs_reg[0] == 8'h01 && regs_reg[4] == 8'h24 &&
         regs_reg[21] == 8'h88 && regs_reg[22] == 8'h00;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("register default not loaded");

   property p_addr_ack;
      @(posedge core_clk) disable iff (!chip_rst_n || core_rst)
      (state_reg == ST_ADDR && scl_fall && !start_ev && !stop_ev &&
         cnt_reg == 4'h8 && shift_reg[7:1] == my_addr) |=>
         sda_oe_reg && state_reg == ST_ADDR_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");

   property p_addr_ignore;
      @(posedge core_clk) disable iff (!chip_rst_n || core_rst)
      (state_reg == ST_ADDR && scl_fall && !start_ev && !stop_ev &&
         cnt_reg == 4'h8 && shift_reg[7:1] != my_addr) |=>
         !sda_oe_reg && state_reg == ST_IDLE;
   endproperty
   a_addr_ignore: assert property (p_addr_ignore)
      else $error("foreign address not ignored");

   property p_ft_sda;
      @(posedge core_clk) disable iff (!chip_rst_n)
      ft_sda_oe_reg |-> $past(passthru_switch_on) && !$past(sda_s, 1);
   endproperty
   a_ft_sda: assert property (p_ft_sda)
      else $error("feed-through data driven while switch off or data high");

   property p_ft_scl;
      @(posedge core_clk) disable iff (!chip_rst_n)
      (passthru_switch_on && !scl_s && !core_rst) ##1 !scl_s |->
         ft_scl_oe_reg && ft_scl_pin.out == 1'b0;
   endproperty
   a_ft_scl: assert property (p_ft_scl)
      else $error("feed-through clock not pulled low");

   property p_sda_when;
      @(posedge core_clk) disable iff (!chip_rst_n)
      sda_oe_reg |-> state_reg inside {ST_ADDR_ACK, ST_INDEX_ACK,
         ST_WDATA_ACK, ST_RDATA};
   endproperty
   a_sda_when: assert property (p_sda_when)
      else $error("data line pulled low outside ack or read data");

   property p_vsync;
      @(posedge core_clk) disable iff (!chip_rst_n)
      vs_oe_reg |-> $past(vsync_en) && $past(vsync_src);
   endproperty
   a_vsync: assert property (p_vsync)
      else $error("vertical pulse driven while disabled");

   property p_write_store;
      @(posedge core_clk) disable iff (!chip_rst_n || core_rst)
      (state_reg == ST_WDATA && scl_fall && !start_ev && !stop_ev &&
         cnt_reg == 4'h8 && idx_reg < 8'h17) |=>
         regs_reg[$past(idx_reg[4:0])] == $past(shift_reg) &&
         idx_reg == $past(idx_reg) + 8'h01;
   endproperty
   a_write_store: assert property (p_write_store)
      else $error("written byte not stored or index not advanced");

   property p_read_next;
      @(posedge core_clk) disable iff (!chip_rst_n || core_rst)
      (state_reg == ST_RDATA && scl_fall && !start_ev && !stop_ev &&
         cnt_reg == 4'h8) |=> idx_reg == $past(idx_reg) + 8'h01 &&
         state_reg == ST_RDATA_ACK && !sda_oe_reg;
   endproperty
   a_read_next: assert property (p_read_next)
      else $error("read index not advanced after a byte");

   c_write: cover property (@(posedge core_clk) state_reg == ST_WDATA_ACK);
   c_read: cover property (@(posedge core_clk) state_reg == ST_RDATA_ACK);
   c_foreign: cover property (@(posedge core_clk)
      state_reg == ST_ADDR ##1 state_reg == ST_IDLE);
   c_feed: cover property (@(posedge core_clk) ft_sda_oe_reg);

endmodule : ctl_port_core

// ==== test/i2c_master_model.sv ====
`timescale 1ns/1ps

module i2c_master_model #(
   parameter int QTR = 16
) (
   // core clock paces the serial bus
   input wire logic core_clk,
   // resolved data wire level
   input wire logic sda_line,
   // clock level and data pull-down
   output logic scl_out,
   output logic sda_pull
);
   // idle bus: clock high, data left to the pull-up
   initial begin
      scl_out = 1'b1;
      sda_pull = 1'b0;
   end

   // four quarters of 16 core cycles make a clock near 390 kHz
   task automatic q(input int n);
      repeat (n * QTR) @(posedge core_clk);
   endtask : q

   // start and repeated start both release data before raising the clock
   task automatic start();
      q(1);
      sda_pull <= 1'b0;
      q(1);
      scl_out <= 1'b1;
      q(1);
      sda_pull <= 1'b1;
      q(1);
      scl_out <= 1'b0;
   endtask : start

   task automatic stop();
      q(1);
      sda_pull <= 1'b1;
      q(1);
      scl_out <= 1'b1;
      q(1);
      sda_pull <= 1'b0;
      q(1);
   endtask : stop

   // data changes a quarter after the clock fall, sampled late in the high
   task automatic bit_io(input logic tx, output logic rx);
      q(1);
      sda_pull <= ~tx;
      q(1);
      scl_out <= 1'b1;
      q(2);
      rx = sda_line;
      scl_out <= 1'b0;
   endtask : bit_io

   // eight bits msb first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
                          output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_tx, ack_rx);
   endtask : byte_io
endmodule : i2c_master_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "ctl_consts.svh"

module tb_top;
   logic core_clk = 1'b0;
   logic ref_clock_in = 1'b0;
   logic resetn = 1'b0;
   logic chip_rst_n = 1'b0;
   logic addr_sel_lo = 1'b0;
   logic addr_sel_hi = 1'b0;
   logic vsync_src = 1'b0;
   logic scl_in;
   logic sda_pull;
   logic sda_in;
   logic running;
   ctl_pkg::od_pin_t sda_pin;
   ctl_pkg::od_pin_t ft_sda_pin;
   ctl_pkg::od_pin_t ft_scl_pin;
   ctl_pkg::od_pin_t vertical_pulse_out;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int ft_scl_cnt = 0;
   int ft_sda_cnt = 0;
   int bad_cnt = 0;
   logic [7:0] rbuf[$];
   logic [7:0] defs[23] = '{`DEF_00, `DEF_01, `DEF_02, `DEF_03, `DEF_04,
      `DEF_05, `DEF_06, `DEF_07, `DEF_08, `DEF_09, `DEF_0A, `DEF_0B, `DEF_0C,
      `DEF_0D, `DEF_0E, `DEF_0F, `DEF_10, `DEF_11, `DEF_12, `DEF_13, `DEF_14,
      `DEF_15, `DEF_16};

   // clocks are unrelated in phase; the reference runs free
   always #20 core_clk = ~core_clk;
   always #15 ref_clock_in = ~ref_clock_in;

   // pull-up unless someone pulls the data wire low
   assign sda_in = ~(sda_pull | (sda_pin.oe === 1'b1));

   ctl_port_core i_ctl_port_core (
      .core_clk(core_clk), .resetn(resetn), .ref_clock_in(ref_clock_in),
      .chip_rst_n(chip_rst_n), .addr_sel_lo(addr_sel_lo),
      .addr_sel_hi(addr_sel_hi), .scl_in(scl_in), .sda_in(sda_in),
      .sda_pin(sda_pin), .vsync_src(vsync_src), .ft_sda_pin(ft_sda_pin),
      .ft_scl_pin(ft_scl_pin), .vertical_pulse_out(vertical_pulse_out),
      .running(running));

   i2c_master_model i_i2c_master_model (
      .core_clk(core_clk), .sda_line(sda_in), .scl_out(scl_in),
      .sda_pull(sda_pull));

   // pin watch and hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (ft_scl_pin.oe === 1'b1) ft_scl_cnt++;
      if (ft_sda_pin.oe === 1'b1) ft_sda_cnt++;
      if ({sda_pin.out, ft_sda_pin.out, ft_scl_pin.out,
           vertical_pulse_out.out} !== 4'h0) bad_cnt++;
      if (cyc == 90000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [7:0] dev_addr(input logic rw);
      return {3'h4, addr_sel_hi, 2'h1, addr_sel_lo, rw};
   endfunction : dev_addr

   // one byte from the master; ack expected as given (0 = acked)
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic [7:0] r;
      logic a;
      i_i2c_master_model.byte_io(b, 1'b1, r, a);
      check({7'h0, a}, {7'h0, exp_ack});
   endtask : send

   task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
      i_i2c_master_model.start();
      send(dev_addr(1'b0), 1'b0);
      send(idx, 1'b0);
      foreach (d[i]) send(d[i], 1'b0);
      i_i2c_master_model.stop();
   endtask : wr

   // read n bytes; master nacks the last one
   task automatic rd(input logic [7:0] idx, input int n);
      logic [7:0] r;
      logic a;
      i_i2c_master_model.start();
      send(dev_addr(1'b0), 1'b0);
      send(idx, 1'b0);
      i_i2c_master_model.start();
      send(dev_addr(1'b1), 1'b0);
      rbuf.delete();
      for (int i = 0; i < n; i++) begin
         i_i2c_master_model.byte_io(8'hff, i == n - 1, r, a);
         rbuf.push_back(r);
      end
      i_i2c_master_model.stop();
   endtask : rd

   task automatic test_defaults();
      rd(8'h00, 23);
      foreach (defs[i]) check(rbuf[i], defs[i]);
      $display("test defaults done");
   endtask : test_defaults

   // index 0x17 is past the file: write dropped, read gives zero
   task automatic test_write_read();
      wr(8'h02, '{8'h05, 8'h04});
      rd(8'h02, 2);
      check(rbuf[0], 8'h05);
      check(rbuf[1], 8'h04);
      wr(8'h15, '{8'h3c, 8'h00, 8'h77});
      rd(8'h15, 3);
      check(rbuf[0], 8'h3c);
      check(rbuf[1], 8'h00);
      check(rbuf[2], 8'h00);
      $display("test write read done");
   endtask : test_write_read

   task automatic test_address();
      logic [7:0] bad;
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         addr_sel_lo <= k[0];
         addr_sel_hi <= k[1];
         repeat (8) @(posedge core_clk);
         wr(8'h01, '{8'(k)});
         // foreign address: nothing acked, nothing stored
         bad = dev_addr(1'b0) ^ (k[0] ? 8'h02 : 8'h10);
         i_i2c_master_model.start();
         send(bad, 1'b1);
         send(8'h01, 1'b1);
         send(8'hee, 1'b1);
         i_i2c_master_model.stop();
         rd(8'h01, 1);
         check(rbuf[0], 8'(k));
      end
      $display("test address done");
   endtask : test_address

   task automatic test_passthru();
      ft_scl_cnt = 0;
      ft_sda_cnt = 0;
      rd(8'h00, 1);
      check(8'(ft_scl_cnt), 8'h00);
      check(8'(ft_sda_cnt), 8'h00);
      wr(8'h16, '{8'h01});
      ft_scl_cnt = 0;
      ft_sda_cnt = 0;
      rd(8'h00, 1);
      check({7'h0, ft_scl_cnt > 0}, 8'h01);
      check({7'h0, ft_sda_cnt > 0}, 8'h01);
      wr(8'h16, '{8'h00});
      check(8'(bad_cnt), 8'h00);
      $display("test passthru done");
   endtask : test_passthru

   task automatic test_vsync();
      wr(8'h16, '{8'h02});
      vsync_src <= 1'b1;
      repeat (3) @(posedge core_clk);
      check({7'h0, vertical_pulse_out.oe}, 8'h01);
      vsync_src <= 1'b0;
      repeat (3) @(posedge core_clk);
      check({7'h0, vertical_pulse_out.oe}, 8'h00);
      wr(8'h16, '{8'h00});
      vsync_src <= 1'b1;
      repeat (3) @(posedge core_clk);
      check({7'h0, vertical_pulse_out.oe}, 8'h00);
      vsync_src <= 1'b0;
      $display("test vsync done");
   endtask : test_vsync

   // the drop must land within 1 ns, with no clock edge
   task automatic test_chip_reset();
      int n;
      wr(8'h00, '{8'h55});
      @(posedge core_clk);
      chip_rst_n <= 1'b0;
      #1;
      check({7'h0, running}, 8'h00);
      check({7'h0, sda_pin.oe}, 8'h00);
      repeat (5) @(negedge ref_clock_in);
      @(posedge core_clk);
      chip_rst_n <= 1'b1;
      repeat (3) @(negedge ref_clock_in);
      #1;
      check({7'h0, running}, 8'h00);
      @(negedge ref_clock_in);
      n = 0;
      while (running !== 1'b1 && n < 10) begin
         @(posedge core_clk);
         n++;
      end
      check({7'h0, n <= 6}, 8'h01);
      rd(8'h00, 1);
      check(rbuf[0], `DEF_00);
      $display("test chip reset done");
   endtask : test_chip_reset

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   // main sequence
   initial begin
      // chip reset first, over four core clock edges; the defaults load once it is released
      repeat (4) @(posedge core_clk);
      chip_rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 200 && running !== 1'b1; i++) begin
         @(posedge core_clk);
      end
      check({7'h0, running}, 8'h01);
      test_defaults();
      test_write_read();
      test_address();
      test_passthru();
      test_vsync();
      test_chip_reset();
      finish_test();
   end
endmodule : tb_top
